// [core/pdac_pkg.sv]
package pdac_pkg;

    // Peripheral address space, data buffer, counter and divider widths.
    localparam int          ADDR_W = 7;
    localparam int          DATA_W = 8;
    localparam int          CNT_W  = 8;
    localparam int          DIV_W  = 11;

    // Peripheral addresses of the two duty registers.
    localparam logic [6:0]  ADDR_DUTY_CH0 = 7'h05;
    localparam logic [6:0]  ADDR_DUTY_CH1 = 7'h06;

    // Reset values. The duty registers have no defined power-on value, so zero is used.
    localparam logic [7:0]  DUTY_RST      = 8'h00;
    localparam logic [7:0]  RDATA_RST     = 8'h00;
    localparam logic        MODE_PORT     = 1'b0;
    localparam logic        MODE_PWM      = 1'b1;

    // Mode control bit positions.
    localparam int          MODE_BIT_CH0  = 0;
    localparam int          MODE_BIT_CH1  = 1;

    // Timing.
    localparam int          SYS_CLK_HZ    = 250_000_000;
    localparam int          BASE_CLK_HZ   = 225_000;
    localparam int          BASE_DIV      = SYS_CLK_HZ / BASE_CLK_HZ;
    localparam logic [10:0] DIV_LAST      = 11'(BASE_DIV - 1);
    localparam logic [10:0] QUARTER_CYC   = 11'(BASE_DIV / 4);
    localparam int          PHASE_CH0     = 0;
    localparam int          PHASE_CH1     = BASE_DIV / 2;
    localparam logic [7:0]  CNT_LAST      = 8'hff;

    // Open-drain pin: the pin is only ever pulled low.
    typedef struct packed {
        logic o;
        logic oe;
    } pdac_pin_s;

    localparam pdac_pin_s   PIN_RST       = '{o: 1'b0, oe: 1'b0};

endpackage

// [core/pdac_channel.sv]
`timescale 1ns/100ps
module pdac_channel #(
    parameter int PHASE = 0
) (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // Duty value
    input  wire logic [7:0] duty,
    // Modulated level
    output logic            level
);

    logic [10:0] div_r;
    logic [10:0] div_nxt;
    logic [7:0]  cnt_r;
    logic [7:0]  cnt_nxt;
    logic        level_r;
    logic        level_nxt;

    // The divider keeps running through halt and chip-enable reset, so the waveform never stalls.
    always_comb begin
        div_nxt   = div_r + 11'h001; // RQ3
        cnt_nxt   = cnt_r;
        if (div_r == pdac_pkg::DIV_LAST) begin // RQ10
            div_nxt = 11'h000;
            cnt_nxt = (cnt_r == pdac_pkg::CNT_LAST) ? 8'h00 : cnt_r + 8'h01; // RQ11
        end
        // High while duty exceeds the count, plus a quarter step when they are equal.
        level_nxt = (duty > cnt_r) || // RQ4
                    ((duty == cnt_r) && (div_r < pdac_pkg::QUARTER_CYC)); // RQ5
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_r   <= 11'(PHASE); // RQ6
            cnt_r   <= 8'h00;
            level_r <= 1'b0;
        end else begin
            div_r   <= div_nxt;
            cnt_r   <= cnt_nxt; // RQ2
            level_r <= level_nxt;
        end
    end

    assign level = level_r;

endmodule

// [core/pdac_top.sv]
// Function
// RQ1: Each pin independently selects port output or modulated output by mode bit.
// RQ2: Output period is 256 base-clock cycles, duty adjustable in 256 steps.
// RQ3: Base clock of 225 kHz derived per channel advances its duty counter.
// RQ4: Pin high while duty register exceeds eight-bit count, low while below.
// RQ5: Quarter-step offset added, so a short high pulse appears at duty zero.
// RQ6: Both base clocks share frequency but run with a fixed phase offset.
// RQ7: Duty registers load independently from data buffer at addresses 05h and 06h.
// RQ8: Power-on reset forces port mode; duty registers hold an arbitrary value.
// RQ9: Clock stop forces port mode with latch value; duty registers keep contents.
// RQ10: Halt and chip-enable reset leave configuration and waveform untouched.
// RQ11: Counters wrap from maximum to zero; port mode drives the output latch.
`timescale 1ns/100ps
module pdac_top (
    // Clock and power-on reset
    input  wire logic                mclk,
    input  wire logic                rstn,
    // Peripheral access through the data buffer
    input  wire logic [6:0]          periph_addr,
    input  wire logic [7:0]          periph_wdata,
    input  wire logic                periph_wr,
    input  wire logic                periph_rd,
    output logic [7:0]               periph_rdata,
    // Pin mode control and general-purpose output latch
    input  wire logic                mode_wr,
    input  wire logic [1:0]          mode_wdata,
    output logic [1:0]               mode_state,
    input  wire logic [1:0]          port_latch,
    // Clock stop instruction
    input  wire logic                clock_stop,
    // Open-drain pins
    output pdac_pkg::pdac_pin_s      port1_bit1_pin,
    output pdac_pkg::pdac_pin_s      port1_bit2_pin
);

    logic [7:0]          duty_reg_ch0_r;
    logic [7:0]          duty_reg_ch0_nxt;
    logic [7:0]          duty_reg_ch1_r;
    logic [7:0]          duty_reg_ch1_nxt;
    logic [7:0]          rdata_r;
    logic [7:0]          rdata_nxt;
    logic [1:0]          mode_r;
    logic [1:0]          mode_nxt;
    logic                modulated_out_ch0;
    logic                modulated_out_ch1;
    pdac_pkg::pdac_pin_s pin_ch0_r;
    pdac_pkg::pdac_pin_s pin_ch0_nxt;
    pdac_pkg::pdac_pin_s pin_ch1_r;
    pdac_pkg::pdac_pin_s pin_ch1_nxt;

    // An open-drain pin pulls low for a low level and releases for a high level.
    function automatic pdac_pkg::pdac_pin_s drive_od(input logic level);
        pdac_pkg::pdac_pin_s p;
        p.o  = 1'b0;
        p.oe = ~level;
        return p;
    endfunction

    // Pin level select between output latch and modulated signal.
    function automatic logic pick(input logic mode, input logic latch, input logic pwm);
        return (mode == pdac_pkg::MODE_PWM) ? pwm : latch;
    endfunction

    // Duty registers and read-back.
    always_comb begin
        duty_reg_ch0_nxt = duty_reg_ch0_r;
        duty_reg_ch1_nxt = duty_reg_ch1_r;
        rdata_nxt        = rdata_r;
        if (periph_wr && (periph_addr == pdac_pkg::ADDR_DUTY_CH0)) begin
            duty_reg_ch0_nxt = periph_wdata; // RQ7
        end
        if (periph_wr && (periph_addr == pdac_pkg::ADDR_DUTY_CH1)) begin
            duty_reg_ch1_nxt = periph_wdata; // RQ7
        end
        // Reads of any other address return zero rather than a stale value.
        if (periph_rd) begin
            unique case (periph_addr)
                pdac_pkg::ADDR_DUTY_CH0: rdata_nxt = duty_reg_ch0_r;
                pdac_pkg::ADDR_DUTY_CH1: rdata_nxt = duty_reg_ch1_r;
                default:                 rdata_nxt = pdac_pkg::RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            duty_reg_ch0_r <= pdac_pkg::DUTY_RST; // RQ8
            duty_reg_ch1_r <= pdac_pkg::DUTY_RST;
            rdata_r        <= pdac_pkg::RDATA_RST;
        end else begin
            // Clock stop does not touch these, so duty values survive it.
            duty_reg_ch0_r <= duty_reg_ch0_nxt; // RQ9
            duty_reg_ch1_r <= duty_reg_ch1_nxt;
            rdata_r        <= rdata_nxt;
        end
    end

    // Pin mode. Clock stop wins over a mode write in the same cycle.
    always_comb begin
        mode_nxt = mode_r;
        if (mode_wr) begin
            mode_nxt = mode_wdata; // RQ1
        end
        if (clock_stop) begin
            mode_nxt = {pdac_pkg::MODE_PORT, pdac_pkg::MODE_PORT}; // RQ9
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= {pdac_pkg::MODE_PORT, pdac_pkg::MODE_PORT}; // RQ8
        end else begin
            mode_r <= mode_nxt;
        end
    end

    pdac_channel #(
        .PHASE (pdac_pkg::PHASE_CH0)
    ) u_ch0 (
        .mclk  (mclk),
        .rstn  (rstn),
        .duty  (duty_reg_ch0_r),
        .level (modulated_out_ch0)
    );

    pdac_channel #(
        .PHASE (pdac_pkg::PHASE_CH1)
    ) u_ch1 (
        .mclk  (mclk),
        .rstn  (rstn),
        .duty  (duty_reg_ch1_r),
        .level (modulated_out_ch1)
    );

    // Pin drivers, registered so the pads never see select glitches.
    always_comb begin
        pin_ch0_nxt = drive_od(pick(mode_r[pdac_pkg::MODE_BIT_CH0],
                                    port_latch[pdac_pkg::MODE_BIT_CH0],
                                    modulated_out_ch0)); // RQ11
        pin_ch1_nxt = drive_od(pick(mode_r[pdac_pkg::MODE_BIT_CH1],
                                    port_latch[pdac_pkg::MODE_BIT_CH1],
                                    modulated_out_ch1)); // RQ1
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_ch0_r <= pdac_pkg::PIN_RST;
            pin_ch1_r <= pdac_pkg::PIN_RST;
        end else begin
            pin_ch0_r <= pin_ch0_nxt;
            pin_ch1_r <= pin_ch1_nxt;
        end
    end

    assign port1_bit1_pin = pin_ch0_r;
    assign port1_bit2_pin = pin_ch1_r;
    assign periph_rdata   = rdata_r;
    assign mode_state     = mode_r;

endmodule

// [tb/pdac_top_properties.sv]
`timescale 1ns/100ps
module pdac_chk (
    // Design ports
    input logic                mclk,
    input logic                rstn,
    input logic [6:0]          periph_addr,
    input logic [7:0]          periph_wdata,
    input logic                periph_wr,
    input logic                periph_rd,
    input logic [7:0]          periph_rdata,
    input logic                mode_wr,
    input logic [1:0]          mode_wdata,
    input logic [1:0]          mode_state,
    input logic [1:0]          port_latch,
    input logic                clock_stop,
    input pdac_pkg::pdac_pin_s port1_bit1_pin,
    input pdac_pkg::pdac_pin_s port1_bit2_pin
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_od; !port1_bit1_pin.o && !port1_bit2_pin.o; endproperty
    a_od: assert property (p_od) else $error("pin drove high");
    // The pins still show their reset value one edge after release, so that edge is left out.
    property p_port0;
        rstn && !mode_state[0] |=> port1_bit1_pin.oe == !$past(port_latch[0]);
    endproperty
    a_port0: assert property (p_port0) else $error("pin0 not latch");
    property p_port1;
        rstn && !mode_state[1] |=> port1_bit2_pin.oe == !$past(port_latch[1]);
    endproperty
    a_port1: assert property (p_port1) else $error("pin1 not latch");
    property p_stop; clock_stop |=> mode_state == 2'b00; endproperty
    a_stop: assert property (p_stop) else $error("mode kept on stop");
    property p_mode; mode_wr && !clock_stop |=> mode_state == $past(mode_wdata); endproperty
    a_mode: assert property (p_mode) else $error("mode not loaded");
    property p_hold; !mode_wr && !clock_stop |=> $stable(mode_state); endproperty
    a_hold: assert property (p_hold) else $error("mode drifted");
    property p_unmap; periph_rd && !(periph_addr inside {7'h05, 7'h06}) |=> periph_rdata == 8'h00;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_wrrd;
        periph_wr && periph_addr == 7'h05 ##1 periph_rd && !periph_wr && periph_addr == 7'h05
        |=> periph_rdata == $past(periph_wdata, 2);
    endproperty
    a_wrrd: assert property (p_wrrd) else $error("duty readback");
    c_pwm: cover property (mode_state == 2'b11);
    c_stop: cover property (clock_stop && mode_state != 2'b00);
    c_rd1: cover property (periph_rd && periph_addr == 7'h06);
endmodule
bind pdac_top pdac_chk u_chk (.*);

// [tb/pdac_filter.sv]
`timescale 1ns/100ps
module pdac_filter (
    // Clock, pins and clear
    input logic                mclk,
    input pdac_pkg::pdac_pin_s pin0,
    input pdac_pkg::pdac_pin_s pin1,
    input logic                clr,
    // Wire levels and integrated high time
    output logic [1:0]         lvl,
    output int                 hi0,
    output int                 hi1
);
    // The pull-up lifts a released line, so only an enabled pin can pull it low.
    assign lvl = {!pin1.oe, !pin0.oe};
    always @(posedge mclk) begin
        hi0 <= clr ? 0 : hi0 + lvl[0];
        hi1 <= clr ? 0 : hi1 + lvl[1];
    end
endmodule

// [tb/dual_pwm_dac_output_tb_top.sv]
`timescale 1ns/100ps
module dual_pwm_dac_output_tb_top;
    logic                mclk, rstn, periph_wr, periph_rd, mode_wr, clock_stop, clr;
    logic [6:0]          periph_addr;
    logic [7:0]          periph_wdata, periph_rdata, d0, d1;
    logic [1:0]          mode_wdata, mode_state, port_latch, lvl;
    pdac_pkg::pdac_pin_s port1_bit1_pin, port1_bit2_pin;
    integer              seed = 32'h38eb599a;
    int                  n_fail = 0, comparisons = 0, hi0, hi1;
    always #2 mclk = ~mclk;
    pdac_top DUT (.*);
    pdac_filter u_flt (.mclk, .pin0(port1_bit1_pin), .pin1(port1_bit2_pin), .clr, .lvl, .hi0, .hi1);
    task automatic chk(string w, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", w, e, g);
        end
    endtask
    // A few cycles of slack cover the mode write latency at the window start.
    task automatic near(string w, int e, int g);
        chk(w, e, (g > e - 12 && g < e + 12) ? e : g);
    endtask
    function automatic int exp_hi(logic [7:0] d, int ph);
        int b = pdac_pkg::BASE_DIV;
        if (ph == 0) return d * b + pdac_pkg::QUARTER_CYC;
        return d == 0 ? 0 : b - ph + (d - 1) * b + pdac_pkg::QUARTER_CYC;
    endfunction
    task automatic wreg(logic [6:0] a, logic [7:0] d);
        periph_addr <= a;
        periph_wdata <= d;
        periph_wr <= 1'b1;
        @(posedge mclk);
        periph_wr <= 1'b0;
    endtask
    task automatic rreg(logic [6:0] a, logic [7:0] e);
        periph_addr <= a;
        periph_rd <= 1'b1;
        @(posedge mclk);
        periph_rd <= 1'b0;
        @(posedge mclk);
        chk("rdata", e, periph_rdata);
    endtask
    task automatic setm(logic [1:0] m);
        mode_wdata <= m;
        mode_wr <= 1'b1;
        @(posedge mclk);
        mode_wr <= 1'b0;
    endtask
    task automatic results;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        {mclk, rstn, periph_wr, periph_rd, mode_wr, clock_stop, clr} = 7'h01;
        {periph_addr, periph_wdata, mode_wdata, port_latch} = 19'h00000;
        // The measuring window is short of a full period, so duties stay below 18.
        for (int r = 0; r < 3; r++) begin
            d0 = r == 0 ? 8'h00 : 8'(1 + $unsigned($random(seed)) % 17);
            d1 = r == 0 ? 8'h11 : 8'(1 + $unsigned($random(seed)) % 17);
            port_latch <= 2'b00;
            clr <= 1'b1;
            rstn <= 1'b0;
            repeat (6) @(posedge mclk);
            rstn <= 1'b1;
            clr <= 1'b0;
            wreg(7'h05, d0);
            // An idle edge between two writes keeps the strobe to one assignment per step.
            @(posedge mclk);
            wreg(7'h06, d1);
            setm(2'b11);
            repeat (20000) @(posedge mclk);
            near("hi0", exp_hi(d0, 0), hi0);
            near("hi1", exp_hi(d1, pdac_pkg::PHASE_CH1), hi1);
            port_latch <= 2'($random(seed));
            clock_stop <= 1'b1;
            @(posedge mclk);
            clock_stop <= 1'b0;
            repeat (3) @(posedge mclk);
            chk("mode", 2'b00, mode_state);
            chk("pins", port_latch, lvl);
            rreg(7'h06, d1);
            wreg(7'h07, 8'hff);
            @(posedge mclk);
            wreg(7'h05, d0);
            rreg(7'h05, d0);
            rreg(7'h07, 8'h00);
            setm(2'b10);
            repeat (3) @(posedge mclk);
            chk("pin0", port_latch[0], lvl[0]);
        end
        results;
    end
endmodule
